// *** include/dmc_mode_map.svh ***
// named constants for the base mode register bank and burst sequencer
// assumes inclusion by both the package users and the design modules
`ifndef DMC_MODE_MAP_SVH
`define DMC_MODE_MAP_SVH

// ----------------------------------------------------------------
// register layout
// ----------------------------------------------------------------
`define DMC_MODE_W 17
`define DMC_MODE_RESET 17'h00000
`define DMC_BL_LO 0
`define DMC_BL_HI 1
`define DMC_BT_BIT 3
`define DMC_RL_LO 4
`define DMC_RL_HI 6
`define DMC_DLLRST_BIT 8
`define DMC_WR_LO 9
`define DMC_WR_HI 11
`define DMC_PDLL_BIT 12
`define DMC_BL_FIXED8 2'h0
`define DMC_BL_OTF 2'h1
`define DMC_BL_CHOP4 2'h2
`define DMC_SEL_BASE 2'h0

// ----------------------------------------------------------------
// pins and command fields
// ----------------------------------------------------------------
`define DMC_ADDR_W 14
`define DMC_OTF_BIT 12
`define DMC_PIN_W 24
`define DMC_PIN_CK 23
`define DMC_PIN_RSTN 22
`define DMC_PIN_CKE 21
`define DMC_PIN_CSN 20
`define DMC_PIN_RASN 19
`define DMC_PIN_CASN 18
`define DMC_PIN_WEN 17
`define DMC_PIN_BA_HI 16
`define DMC_PIN_BA_LO 14
// idle levels: selects, strobes, clock enable and reset pin high
`define DMC_PIN_IDLE 24'h7e0000

// ----------------------------------------------------------------
// timing and latency encodings (counts of link clock cycles; beat numbers step each half cycle)
// ----------------------------------------------------------------
`define DMC_LOCK_CYCLES 10'h200
`define DMC_WR_START 4'h1
`define DMC_BEAT_LAST 3'h7
`define DMC_BEAT_CHOP_LAST 3'h3
`define DMC_RL_DEFAULT 4'h5
`define DMC_WR_DEFAULT 4'h5

`endif

// *** include/dmc_pkg.sv ***
// types shared by the mode register bank's command decode and burst sequencer
// assumes dmc_mode_map.svh is included by each user of the constants
package dmc_pkg;

  // ----------------------------------------------------------------
  // sequencer states, gray coded along idle, wait, burst
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DMC_IDLE = 2'h0,
    DMC_WAIT = 2'h1,
    DMC_BURST = 2'h3
  } dmc_state_e;

  // decoded bus commands
  typedef enum logic [1:0] {
    DMC_CMD_OTHER = 2'h0,
    DMC_CMD_MRS = 2'h1,
    DMC_CMD_READ = 2'h2,
    DMC_CMD_WRITE = 2'h3
  } dmc_cmd_e;

endpackage : dmc_pkg

// *** rtl/dmc_burst_order.sv ***
// column order within one burst: start column and beat give the column
// assumes purely combinational use by the sequencer in dmc_mode_bank
`timescale 1ns/10ps

module dmc_burst_order (
  // burst description
  input wire logic [2:0] start_col,
  input wire logic [2:0] beat,
  input wire logic interleaved,
  input wire logic chop,
  input wire logic is_read,
  // resulting column low bits
  output logic [2:0] col
);

  // ----------------------------------------------------------------
  // order selection
  // ----------------------------------------------------------------
  // writes ignore the low start bits: only nibble or word alignment
  always_comb begin
    if (!is_read) begin
      if (chop) begin
        col = {start_col[2], beat[1:0]};
      end else begin
        col = beat;
      end
    end else if (interleaved) begin
      col = start_col ^ beat;
    end else begin
      // wrap in the four-column half, then flip the half for beats 4-7
      col = {start_col[2] ^ beat[2],
             2'(start_col[1:0] + beat[1:0])};
    end
  end

endmodule : dmc_burst_order

// *** rtl/dmc_mode_bank.sv ***
// base mode register bank with field decode and burst column sequencer
// assumes the command pins and the link clock are asynchronous to
// sys_clk and are sampled here; sys_clk must be well above 2x link clock
`timescale 1ns/10ps

`include "dmc_mode_map.svh"

module dmc_mode_bank (
  // system clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // link clock and device reset pin, both asynchronous
  input wire logic link_ck,
  input wire logic dev_reset_n,
  // command bus pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank_addr,
  input wire logic [`DMC_ADDR_W-1:0] addr,
  // decoded settings
  output logic [1:0] burst_length_mode,
  output logic burst_interleaved,
  output logic [3:0] read_latency,
  output logic [3:0] write_recovery_time,
  output logic sleep_keeps_loop,
  // clock alignment loop control
  output logic loop_reset_pulse,
  output logic loop_locked,
  output logic loop_running,
  output logic precharge_sleep,
  // burst sequencer
  output logic beat_valid,
  output logic beat_is_read,
  output logic [2:0] beat_col,
  output logic dq_oe,
  output logic dqs_oe,
  output logic burst_busy
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [`DMC_PIN_W-1:0] pin_raw; // all asynchronous inputs
  logic [`DMC_PIN_W-1:0] pin_meta; // first stage, read by second only
  logic [`DMC_PIN_W-1:0] pin_sync; // second stage, safe to use
  logic ck_prev; // previous synchronised link clock
  // a fresh synchroniser shows idle pins, so it fakes no command, no
  // sleep and no device reset while it fills after reset
  localparam logic [`DMC_PIN_W-1:0] pin_idle = `DMC_PIN_IDLE;

  assign pin_raw = {link_ck, dev_reset_n, cke, cs_n, ras_n, cas_n, we_n,
                    bank_addr, addr};

  // two stages per bit; all pins share the same delay so a command stays
  // aligned with the clock edge that registers it
  genvar gi;
  generate
    for (gi = 0; gi < `DMC_PIN_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
          pin_meta[gi] <= pin_idle[gi];
          pin_sync[gi] <= pin_idle[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  // remember last link clock level for edge finding
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ck_prev <= 1'h0;
    end else begin
      ck_prev <= pin_sync[`DMC_PIN_CK];
    end
  end

  // ----------------------------------------------------------------
  // edge and command decode
  // ----------------------------------------------------------------
  logic ck_rise; // one-cycle enable at each link clock rising edge
  logic ck_fall; // one-cycle enable at each link clock falling edge
  logic pin_rst_n; // synchronised device reset pin
  logic pin_cke; // synchronised clock enable
  logic [2:0] pin_ba; // synchronised bank address
  logic [`DMC_ADDR_W-1:0] pin_addr; // synchronised address
  dmc_pkg::dmc_cmd_e cmd; // command present on this rising edge

  assign ck_rise = pin_sync[`DMC_PIN_CK] & ~ck_prev;
  assign ck_fall = ~pin_sync[`DMC_PIN_CK] & ck_prev;
  assign pin_rst_n = pin_sync[`DMC_PIN_RSTN];
  assign pin_cke = pin_sync[`DMC_PIN_CKE];
  assign pin_ba = pin_sync[`DMC_PIN_BA_HI:`DMC_PIN_BA_LO];
  assign pin_addr = pin_sync[`DMC_ADDR_W-1:0];

  // select, row, column and write strobes to a command
  function automatic dmc_pkg::dmc_cmd_e cmd_decode(
    input logic csn, input logic rasn, input logic casn, input logic wen);
    dmc_pkg::dmc_cmd_e c;
    c = dmc_pkg::DMC_CMD_OTHER;
    if (!csn && !rasn && !casn && !wen) begin
      c = dmc_pkg::DMC_CMD_MRS;
    end else if (!csn && rasn && !casn && wen) begin
      c = dmc_pkg::DMC_CMD_READ;
    end else if (!csn && rasn && !casn && !wen) begin
      c = dmc_pkg::DMC_CMD_WRITE;
    end
    return c;
  endfunction : cmd_decode

  assign cmd = cmd_decode(pin_sync[`DMC_PIN_CSN], pin_sync[`DMC_PIN_RASN],
                          pin_sync[`DMC_PIN_CASN], pin_sync[`DMC_PIN_WEN]);

  // ----------------------------------------------------------------
  // base mode register
  // ----------------------------------------------------------------
  logic [`DMC_MODE_W-1:0] base_mode_config; // programmed word
  logic mrs_hit; // base register write on this edge

  // only bank select zero reaches this register; other selects belong to
  // the other mode registers and are ignored here
  assign mrs_hit = ck_rise & pin_cke & (cmd == dmc_pkg::DMC_CMD_MRS) &
                   (pin_ba[1:0] == `DMC_SEL_BASE);

  // reserved bits are stored as sent; the controller keeps them zero
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      base_mode_config <= `DMC_MODE_RESET;
    end else if (!pin_rst_n) begin
      base_mode_config <= `DMC_MODE_RESET;
    end else if (mrs_hit) begin
      base_mode_config <= {pin_ba[2], pin_ba[1:0], pin_addr};
    end else if (base_mode_config[`DMC_DLLRST_BIT]) begin
      base_mode_config[`DMC_DLLRST_BIT] <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  // latency code to cycles; unlisted codes fall back to five
  function automatic logic [3:0] rl_decode(input logic [2:0] code);
    logic [3:0] v;
    v = `DMC_RL_DEFAULT;
    unique case (code)
      3'h1: v = 4'h5;
      3'h2: v = 4'h6;
      3'h3: v = 4'h7;
      3'h4: v = 4'h8;
      3'h5: v = 4'h9;
      3'h6: v = 4'ha;
      default: v = `DMC_RL_DEFAULT;
    endcase
    return v;
  endfunction : rl_decode

  // recovery code to cycles; unlisted codes fall back to five
  function automatic logic [3:0] wr_decode(input logic [2:0] code);
    logic [3:0] v;
    v = `DMC_WR_DEFAULT;
    unique case (code)
      3'h1: v = 4'h5;
      3'h2: v = 4'h6;
      3'h3: v = 4'h7;
      3'h4: v = 4'h8;
      3'h5: v = 4'ha;
      3'h6: v = 4'hc;
      default: v = `DMC_WR_DEFAULT;
    endcase
    return v;
  endfunction : wr_decode

  // registered settings so they change only one cycle after a program
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      burst_length_mode <= `DMC_BL_FIXED8;
      burst_interleaved <= 1'h0;
      read_latency <= `DMC_RL_DEFAULT;
      write_recovery_time <= `DMC_WR_DEFAULT;
      sleep_keeps_loop <= 1'h0;
    end else begin
      burst_length_mode <= base_mode_config[`DMC_BL_HI:`DMC_BL_LO];
      burst_interleaved <= base_mode_config[`DMC_BT_BIT];
      read_latency <= rl_decode(
        base_mode_config[`DMC_RL_HI:`DMC_RL_LO]);
      write_recovery_time <= wr_decode(
        base_mode_config[`DMC_WR_HI:`DMC_WR_LO]);
      sleep_keeps_loop <= base_mode_config[`DMC_PDLL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // clock alignment loop control
  // ----------------------------------------------------------------
  logic [9:0] lock_cnt; // link clock rises since the last loop reset

  // one pulse as the self-clearing bit is seen set
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      loop_reset_pulse <= 1'h0;
    end else begin
      loop_reset_pulse <= base_mode_config[`DMC_DLLRST_BIT] &
                          ~loop_reset_pulse;
    end
  end

  // lock needs the clock running with clock enable high; the flag is
  // only advice, reads before lock are the controller's hazard
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_cnt <= 10'h0;
      loop_locked <= 1'h0;
    end else if (loop_reset_pulse) begin
      lock_cnt <= 10'h0;
      loop_locked <= 1'h0;
    end else if (ck_rise && pin_cke && !loop_locked) begin
      lock_cnt <= 10'(lock_cnt + 10'h1);
      loop_locked <= (10'(lock_cnt + 10'h1) == `DMC_LOCK_CYCLES);
    end
  end

  // precharge sleep: clock enable low with no burst in flight
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      precharge_sleep <= 1'h0;
      loop_running <= 1'h1;
    end else begin
      precharge_sleep <= ~pin_cke & ~burst_busy;
      // loop stops in sleep unless the keep bit is set
      loop_running <= ~(~pin_cke & ~burst_busy) |
                      base_mode_config[`DMC_PDLL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  dmc_pkg::dmc_state_e state; // sequencer state
  logic [3:0] lat_left; // rising edges still to wait
  logic [2:0] start_col; // captured low column bits
  logic [2:0] beat; // current beat slot
  logic cur_read; // burst is a read
  logic cur_chop; // burst is chopped to four beats
  logic cur_il; // burst uses interleaved order
  logic [2:0] order_col; // column for the current beat
  logic cmd_take; // read or write accepted on this edge
  logic otf_chop; // chop decision for the command on the bus

  assign cmd_take = ck_rise & pin_cke & (state == dmc_pkg::DMC_IDLE) &
                    ((cmd == dmc_pkg::DMC_CMD_READ) |
                     (cmd == dmc_pkg::DMC_CMD_WRITE));

  // one setting for both directions; A12 only matters on-the-fly
  always_comb begin
    unique case (base_mode_config[`DMC_BL_HI:`DMC_BL_LO])
      `DMC_BL_OTF: otf_chop = ~pin_addr[`DMC_OTF_BIT];
      `DMC_BL_CHOP4: otf_chop = 1'h1;
      default: otf_chop = 1'h0;
    endcase
  end

  // state walk: commands during a burst are ignored, the controller
  // spaces them; chop bursts keep the eight-beat start point
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= dmc_pkg::DMC_IDLE;
      lat_left <= 4'h0;
      beat <= 3'h0;
    end else if (!pin_rst_n) begin
      state <= dmc_pkg::DMC_IDLE;
      lat_left <= 4'h0;
      beat <= 3'h0;
    end else begin
      unique case (state)
        dmc_pkg::DMC_IDLE: begin
          if (cmd_take) begin
            state <= dmc_pkg::DMC_WAIT;
            lat_left <= (cmd == dmc_pkg::DMC_CMD_READ) ?
                        read_latency : `DMC_WR_START;
          end
        end
        dmc_pkg::DMC_WAIT: begin
          if (ck_rise) begin
            lat_left <= 4'(lat_left - 4'h1);
            if (lat_left == 4'h1) begin
              state <= dmc_pkg::DMC_BURST;
              beat <= 3'h0;
            end
          end
        end
        dmc_pkg::DMC_BURST: begin
          if (ck_rise || ck_fall) begin
            if (beat == `DMC_BEAT_LAST) begin
              state <= dmc_pkg::DMC_IDLE;
            end else begin
              beat <= 3'(beat + 3'h1);
            end
          end
        end
      endcase
    end
  end

  // burst description captured with the command
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      start_col <= 3'h0;
      cur_read <= 1'h0;
      cur_chop <= 1'h0;
      cur_il <= 1'h0;
    end else if (cmd_take) begin
      start_col <= pin_addr[2:0];
      cur_read <= (cmd == dmc_pkg::DMC_CMD_READ);
      cur_chop <= otf_chop;
      cur_il <= base_mode_config[`DMC_BT_BIT];
    end
  end

  // column order for the slot about to be presented
  dmc_burst_order u_order (
    .start_col(start_col),
    .beat(beat),
    .interleaved(cur_il),
    .chop(cur_chop),
    .is_read(cur_read),
    .col(order_col)
  );

  // ----------------------------------------------------------------
  // beat outputs
  // ----------------------------------------------------------------
  // registered one cycle behind the state so data outputs are clean;
  // chopped slots 4-7 leave the drivers off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      beat_valid <= 1'h0;
      beat_is_read <= 1'h0;
      beat_col <= 3'h0;
      dq_oe <= 1'h0;
      dqs_oe <= 1'h0;
    end else if (state == dmc_pkg::DMC_BURST) begin
      beat_valid <= ~cur_chop | (beat <= `DMC_BEAT_CHOP_LAST);
      beat_is_read <= cur_read;
      beat_col <= order_col;
      dq_oe <= cur_read & (~cur_chop |
               (beat <= `DMC_BEAT_CHOP_LAST));
      dqs_oe <= cur_read & (~cur_chop |
                (beat <= `DMC_BEAT_CHOP_LAST));
    end else begin
      beat_valid <= 1'h0;
      beat_is_read <= 1'h0;
      dq_oe <= 1'h0;
      dqs_oe <= 1'h0;
    end
  end

  assign burst_busy = (state != dmc_pkg::DMC_IDLE);

endmodule : dmc_mode_bank

// *** sim/dmc_ctl_model.sv ***
// controller model: free link clock, command, cke and reset pins
// assumes the bench calls its tasks one at a time from one process
`timescale 1ns/10ps

`include "dmc_mode_map.svh"

module dmc_ctl_model (
  // bench clock, times every command, cke and reset pin change
  input wire logic sys_clk,
  // memory side pins
  output logic link_ck,
  output logic dev_reset_n,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank_addr,
  output logic [`DMC_ADDR_W-1:0] addr
);
  int since = 0; // link rises since the last command went out

  // --------------------
  // clock and idle pins
  // --------------------
  initial begin
    link_ck = 1'b0;
    {dev_reset_n, cke, cs_n, ras_n, cas_n, we_n} = 6'h3f;
    bank_addr = 3'h0;
    addr = 14'h0;
  end
  // memory clock runs free, 160 ns period
  always #80 link_ck = ~link_ck;
  always @(posedge link_ck) since <= since + 1;

  // --------------------
  // command tasks
  // --------------------
  // one command for one link cycle; deselected lines show junk after
  task automatic cmd(input logic [3:0] c, input logic [2:0] ba,
                     input logic [13:0] a);
    @(negedge link_ck);
    @(posedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    bank_addr <= ba;
    addr <= a;
    since <= 0;
    @(negedge link_ck);
    @(posedge sys_clk);
    {cs_n, ras_n, cas_n, we_n} <= 4'hf;
    bank_addr <= ~ba; // stale lines must not be relied on
    addr <= ~a;
  endtask : cmd
  // mode set: reserved bits low, every field sent each time
  task automatic mrs(input logic [16:0] v);
    cmd(4'h0, 3'h0, v[13:0] & 14'h1f7b);
  endtask : mrs
  // bench waits for lock and for idle before calling these
  task automatic rd(input logic [13:0] a);
    cmd(4'h5, 3'h0, a);
  endtask : rd
  task automatic wr(input logic [13:0] a);
    cmd(4'h4, 3'h0, a);
  endtask : wr
  task automatic pins(input logic k, input logic r);
    @(posedge sys_clk);
    cke <= k;
    dev_reset_n <= r;
  endtask : pins
endmodule : dmc_ctl_model

// *** sim/dmc_mode_bank_monitor.sv ***
// checker for the mode register bank: watches only the top's ports
// assumes one sys_clk domain and bind from the bench top file
`timescale 1ns/10ps

module dmc_mode_bank_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // decoded settings
  input wire logic [1:0] burst_length_mode,
  input wire logic [3:0] read_latency,
  input wire logic [3:0] write_recovery_time,
  input wire logic sleep_keeps_loop,
  // loop control
  input wire logic loop_reset_pulse,
  input wire logic loop_locked,
  input wire logic loop_running,
  input wire logic precharge_sleep,
  // sequencer
  input wire logic beat_valid,
  input wire logic beat_is_read,
  input wire logic dq_oe,
  input wire logic dqs_oe,
  input wire logic burst_busy
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  oe_read_only_a:
    assert property (dq_oe |-> beat_valid && beat_is_read)
    else $error("data driver on outside a read beat");
  strobe_with_data_a:
    assert property (dq_oe == dqs_oe)
    else $error("strobe and data drivers disagree");
  valid_in_burst_a:
    assert property (beat_valid |-> $past(burst_busy))
    else $error("beat outside a busy burst");
  pulse_single_a:
    assert property (loop_reset_pulse |=> !loop_reset_pulse)
    else $error("loop reset pulse longer than one cycle");
  pulse_unlocks_a:
    assert property (loop_reset_pulse |-> ##[1:2] !loop_locked)
    else $error("lock kept across a loop reset");
  latency_legal_a:
    assert property (read_latency inside {[4'h5:4'ha]})
    else $error("read latency out of range");
  recovery_legal_a:
    assert property (write_recovery_time inside
      {4'h5, 4'h6, 4'h7, 4'h8, 4'ha, 4'hc})
    else $error("write recovery not a listed value");
  sleep_keeps_a:
    assert property ((precharge_sleep && sleep_keeps_loop) [*3]
      |-> loop_running)
    else $error("loop stopped although kept in sleep");
  awake_runs_a:
    assert property ((!precharge_sleep) [*3] |-> loop_running)
    else $error("loop stopped outside sleep");
  settings_hold_a:
    assert property (burst_busy && $past(burst_busy) |->
      $stable(read_latency) && $stable(burst_length_mode))
    else $error("settings changed during a burst");
  length_code_a:
    assert property (burst_length_mode != 2'h3)
    else $error("undefined burst length setting");
endmodule : dmc_mode_bank_monitor

// *** sim/tb_dmc_mode_bank.sv ***
// bench for the mode register bank: random settings and bursts
// assumes dmc_ctl_model drives every pin on the memory side
`timescale 1ns/10ps

`include "dmc_mode_map.svh"

module tb_dmc_mode_bank;
  // --------------------
  // signals
  // --------------------
  logic sys_clk = 1'b0; // 125 MHz
  logic reset = 1'b1; // held two cycles
  logic link_ck, dev_reset_n, cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] bank_addr, beat_col;
  logic [`DMC_ADDR_W-1:0] addr;
  logic [1:0] burst_length_mode;
  logic [3:0] read_latency, write_recovery_time;
  logic burst_interleaved, sleep_keeps_loop, loop_reset_pulse;
  logic loop_locked, loop_running, precharge_sleep, beat_valid;
  logic beat_is_read, dq_oe, dqs_oe, burst_busy;
  int n_errors = 0;
  int cmp_count = 0;
  int n_pulse = 0; // loop reset pulses seen

  always #4 sys_clk = ~sys_clk;

  // count loop reset pulses; the pulse is over before mrs returns
  always @(posedge sys_clk) begin
    if (loop_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
  end

  dmc_ctl_model ctl_u (.sys_clk(sys_clk), .link_ck(link_ck),
    .dev_reset_n(dev_reset_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank_addr(bank_addr), .addr(addr));

  dmc_mode_bank dut_u (.sys_clk(sys_clk), .reset(reset),
    .link_ck(link_ck), .dev_reset_n(dev_reset_n), .cke(cke),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_addr(bank_addr), .addr(addr),
    .burst_length_mode(burst_length_mode),
    .burst_interleaved(burst_interleaved), .read_latency(read_latency),
    .write_recovery_time(write_recovery_time),
    .sleep_keeps_loop(sleep_keeps_loop),
    .loop_reset_pulse(loop_reset_pulse), .loop_locked(loop_locked),
    .loop_running(loop_running), .precharge_sleep(precharge_sleep),
    .beat_valid(beat_valid), .beat_is_read(beat_is_read),
    .beat_col(beat_col), .dq_oe(dq_oe), .dqs_oe(dqs_oe),
    .burst_busy(burst_busy));

  // --------------------
  // helpers
  // --------------------
  // codes 1..6 only are ever programmed
  function automatic logic [3:0] rl_of(input logic [2:0] c);
    return 4'(c) + 4'h4;
  endfunction : rl_of
  function automatic logic [3:0] wr_of(input logic [2:0] c);
    return c == 3'h5 ? 4'ha : c == 3'h6 ? 4'hc : 4'(c) + 4'h4;
  endfunction : wr_of
  function automatic logic [2:0] col_of(input logic [2:0] s,
    input logic [2:0] k, input logic il, input logic ch, input logic rd);
    if (!rd) return ch ? {s[2], k[1:0]} : k;
    if (il) return s ^ k;
    return {s[2] ^ k[2], s[1:0] + k[1:0]};
  endfunction : col_of

  task automatic stop_test;
    if (n_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic give_up;
    n_errors++;
    stop_test;
  endtask : give_up
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // one burst, sampled mid-slot; slots are 10 sys cycles each
  task automatic burst(input logic rd, input logic [13:0] a,
    input logic [1:0] bl, input logic il, input logic [3:0] m);
    logic ch;
    int n;
    ch = bl == 2'h2 || (bl == 2'h1 && !a[12]);
    n = 0;
    while (burst_busy !== 1'b0 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 400) give_up;
    if (rd) ctl_u.rd(a);
    else ctl_u.wr(a);
    while (beat_valid !== 1'b1 && n < 800) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 800) give_up;
    chk("rises to beat", rd ? 8'(m) + 8'h1 : 8'h2, 8'(ctl_u.since));
    repeat (5) @(negedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      chk("beat_valid", 8'(!(ch && k > 3)), 8'(beat_valid));
      if (beat_valid === 1'b1)
        chk("beat_col", 8'(col_of(a[2:0], 3'(k), il, ch, rd)),
          8'(beat_col));
      chk("beat_is_read", 8'(rd), 8'(beat_is_read));
      chk("dq_oe", 8'(rd && !(ch && k > 3)), 8'(dq_oe));
      chk("dqs_oe", 8'(rd && !(ch && k > 3)), 8'(dqs_oe));
      repeat (10) @(negedge sys_clk);
    end
  endtask : burst

  // --------------------
  // main sequence
  // --------------------
  initial begin
    logic [16:0] v;
    logic [13:0] a;
    logic [1:0] bl;
    logic [2:0] rl, wr;
    logic bt, pd;
    void'($urandom(32'h466be42e));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk("read_latency", 8'h5, 8'(read_latency));
    chk("write_recovery_time", 8'h5, 8'(write_recovery_time));
    chk("loop_running", 8'h1, 8'(loop_running));
    // loop reset first, reads only after the lock count
    ctl_u.mrs(17'h00312);
    repeat (20) @(negedge sys_clk);
    chk("loop_reset_pulse", 8'h1, 8'(n_pulse));
    repeat (500 * 20) @(negedge sys_clk);
    chk("loop_locked", 8'h0, 8'(loop_locked));
    repeat (30 * 20) @(negedge sys_clk);
    chk("loop_locked", 8'h1, 8'(loop_locked));
    for (int i = 0; i < 24; i++) begin
      bl = 2'(i % 3);
      bt = 1'($urandom);
      rl = 3'(1 + $urandom % 6);
      wr = 3'(1 + $urandom % 6);
      pd = 1'($urandom);
      v = {4'h0, pd, wr, 2'h0, rl, bt, 1'b0, bl};
      ctl_u.mrs(v);
      repeat (60) @(negedge sys_clk);
      chk("burst_length_mode", 8'(bl), 8'(burst_length_mode));
      chk("burst_interleaved", 8'(bt), 8'(burst_interleaved));
      chk("read_latency", 8'(rl_of(rl)), 8'(read_latency));
      chk("write_recovery", 8'(wr_of(wr)), 8'(write_recovery_time));
      chk("sleep_keeps_loop", 8'(pd), 8'(sleep_keeps_loop));
      a = 14'($urandom);
      if (i < 3) a[2:0] = 3'h7; // wrap corner
      burst(1'b1, a, bl, bt, rl_of(rl));
      burst(1'b0, 14'($urandom), bl, bt, rl_of(rl));
    end
    // set to another bank is not taken
    ctl_u.cmd(4'h0, 3'h2, 14'h1f7b);
    repeat (60) @(negedge sys_clk);
    chk("burst_length_mode", 8'h2, 8'(burst_length_mode));
    // device reset pin clears the register
    ctl_u.pins(1'b1, 1'b0);
    repeat (10) @(negedge sys_clk);
    ctl_u.pins(1'b1, 1'b1);
    repeat (10) @(negedge sys_clk);
    chk("burst_length_mode", 8'h0, 8'(burst_length_mode));
    // sleep with loop kept and stopped
    for (int p = 0; p < 2; p++) begin
      ctl_u.mrs({4'h0, 1'(p), 12'h210});
      repeat (60) @(negedge sys_clk);
      ctl_u.pins(1'b0, 1'b1);
      repeat (80) @(negedge sys_clk);
      chk("precharge_sleep", 8'h1, 8'(precharge_sleep));
      chk("loop_running", 8'(p), 8'(loop_running));
      ctl_u.pins(1'b1, 1'b1);
      repeat (80) @(negedge sys_clk);
      chk("loop_running", 8'h1, 8'(loop_running));
    end
    // the bit cleared itself: no further pulse from later sets
    chk("loop_reset_pulse", 8'h1, 8'(n_pulse));
    stop_test;
  end

  // hang guard
  initial begin
    #600000;
    give_up;
  end
endmodule : tb_dmc_mode_bank

bind dmc_mode_bank dmc_mode_bank_monitor mon_u (.sys_clk(sys_clk),
  .reset(reset), .burst_length_mode(burst_length_mode),
  .read_latency(read_latency), .write_recovery_time(write_recovery_time),
  .sleep_keeps_loop(sleep_keeps_loop),
  .loop_reset_pulse(loop_reset_pulse), .loop_locked(loop_locked),
  .loop_running(loop_running), .precharge_sleep(precharge_sleep),
  .beat_valid(beat_valid), .beat_is_read(beat_is_read), .dq_oe(dq_oe),
  .dqs_oe(dqs_oe), .burst_busy(burst_busy));
